// *** rtl/microcode_sequencer_registers.sv ***
`timescale 1ns/100ps
`include "sequencer_regs.svh"
module microcode_sequencer_registers import sequencer_pkg::*; #(
	parameter bit AUTO_RESTART = 1'b0,
	parameter int PAGES        = `PAGE_COUNT
) (
	input  wire logic           REF_CLK,
	input  wire logic           NRST,
	input  wire store_load_type STORE_LOAD,
	input  wire mem_read_type   MEM_READ,
	input  wire logic           SLAVE_LOAD_STROBE,
	input  wire logic           HALFWORD_XFER,
	input  wire logic           FALSE_SYNC,
	input  wire logic [15:0]    IO_DATA_IN,
	output logic [15:0]         MEM_ADDR,
	output logic [15:0]         MEM_WDATA,
	output logic [9:0]          MICROADDRESS,
	output micro_word_type      MICROINSTRUCTION,
	output logic [15:0]         INSTRUCTION,
	output logic [3:0]          FLAGS,
	output logic [3:0]          CONDITION_CODE,
	output logic [15:0]         RESULT_BUS,
	output logic                SKIP_ACTIVE
);
	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_pipe;    // release synchroniser
	logic       rst_n;       // released copy

	// two stages so release never lands mid-edge
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [19:0]   cs_mem [0:PAGES-1][0:`PAGE_WORDS-1]; // control store
	logic [11:0]   decode_rom_mem [0:`PAGE_WORDS-1];          // decode rom
	logic [255:0]  legal;                               // legal op map
	logic [9:0]    microaddress_register;               // next fetch
	micro_word_type mir;                                // microinstruction
	logic          skip;                                // one cycle stall
	logic [15:0]   memory_address_latch;
	logic [15:0]   memory_address_slave;
	logic [15:0]   memory_data_latch;
	logic [15:0]   instruction_latch;
	logic [15:0]   second_operand_latch;
	logic [3:0]    flag_bank;
	logic [3:0]    condition_code;
	logic [15:0]   stack [0:`STACK_DEPTH-1];            // register stack

	// ----------------------------------------
	// control store parts
	// ----------------------------------------
	logic [19:0] page_out [0:PAGES-1]; // per page word
	logic [19:0] cs_word;              // wired and of pages

	for (genvar p = 0; p < PAGES; p++) begin : g_page
		logic page_en_n; // page select, low active
		logic read_en_n; // read enable, low active
		assign page_en_n = (microaddress_register[9:8] != 2'(p));
		// parts are read whenever the store clock runs, the skip cycle included
		assign read_en_n = skip_cause;
		for (genvar k = 0; k < `PART_COUNT; k++) begin : g_part
			assign page_out[p][k*4 +: 4] = (!page_en_n && !read_en_n) ?
				cs_mem[p][microaddress_register[7:0]][k*4 +: 4] : 4'hF;
		end
	end

	// disabled pages float high, so and them
	always_comb begin
		cs_word = 20'hF_FFFF;
		for (int p = 0; p < PAGES; p++) begin
			cs_word = cs_word & page_out[p];
		end
	end

	// store contents are written through the load port
	always_ff @(posedge REF_CLK) begin
		if (STORE_LOAD.cs_we && (int'(STORE_LOAD.cs_addr[9:8]) < PAGES)) begin
			cs_mem[STORE_LOAD.cs_addr[9:8]][STORE_LOAD.cs_addr[7:0]] <= STORE_LOAD.cs_data;
		end
		if (STORE_LOAD.decode_rom_we) begin
			decode_rom_mem[STORE_LOAD.decode_rom_addr] <= STORE_LOAD.decode_rom_data;
		end
	end

	// legality map cleared at reset: all op codes illegal
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			legal <= '0;
		end else if (STORE_LOAD.legal_we) begin
			legal[STORE_LOAD.legal_addr] <= STORE_LOAD.legal_bit;
		end
	end

	// ----------------------------------------
	// decode and next address
	// ----------------------------------------
	// decoded op code function, 128 combinations
	function automatic logic [6:0] decode_index(input logic [7:0] op);
		decode_index = op[6:0] ^ {7{op[7]}};
	endfunction

	micro_class_type op_class;        // class of current word
	logic            exec;            // word executes this cycle
	logic            illegal_op;      // op code not legal
	logic [11:0]     decode_rom_out;        // decode rom output
	logic [9:0]      next_address_bus;
	logic            branch_taken;

	assign op_class   = micro_class_type'(mir.op);
	assign exec       = !skip;
	assign illegal_op = !legal[instruction_latch[15:8]];

	// select bit picks first or second decode
	// illegal op disables rom, ones come out
	assign decode_rom_out = illegal_op ? 12'hFFF :
		decode_rom_mem[{mir.shift[0], decode_index(instruction_latch[15:8])}];

	// branch tests flag bank against the condition mask
	assign branch_taken = (mir.dst[4:1] == 4'h0) ||
		((flag_bank & mir.dst[4:1]) != 4'h0);

	// the bus is active low; forcing a bit low sets it
	always_comb begin
		logic [9:0] bus_n;
		bus_n = 10'h3FF;
		if (op_class == OP_DECODE) begin
			bus_n = decode_rom_out[9:0];
			// ones plus forced bit give entry 008
			if (illegal_op) begin
				bus_n[`ILLEGAL_BIT] = 1'b0;
			end
		end else begin
			bus_n = ~mir[9:0];
		end
		if (HALFWORD_XFER) begin
			bus_n[`HALFWORD_BIT] = 1'b0;
		end
		next_address_bus = ~bus_n;
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	logic skip_cause; // this word needs an extra cycle
	assign skip_cause = exec && ((op_class == OP_DECODE) ||
		(op_class == OP_IREAD) || ((op_class == OP_BRANCH) && branch_taken));

	// skip set for one cycle, always cleared next
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			skip <= 1'b0;
		end else begin
			skip <= skip_cause;
		end
	end

	// microaddress register and its page counter
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			microaddress_register <= 10'h000;
		end else if (exec && (op_class == OP_DECODE)) begin
			microaddress_register <= next_address_bus;
		end else if (exec && (op_class == OP_BRANCH) && branch_taken) begin
			microaddress_register <= next_address_bus;
		end else if (!skip_cause) begin
			// count within the page, the skip edge fetches too
			microaddress_register[7:0] <= microaddress_register[7:0] + 8'h01;
		end
	end

	// capture only on an unskipped store clock
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			mir <= AUTO_RESTART ? `MIR_RESET_RESTART : `MIR_RESET_NORMAL;
		end else if (!skip_cause) begin
			// the store clock is only withheld on the edge ending the first cycle of a two-cycle word
			mir <= cs_word;
		end
	end

	// ----------------------------------------
	// operand bus, shifter, alu
	// ----------------------------------------
	logic [3:0]  yd;          // destination field
	logic [3:0]  ys;          // source field
	logic [15:0] operand_bus;
	logic [15:0] a_in;        // shifted operand
	logic [15:0] b_in;        // gated second operand
	logic [16:0] sum;
	logic [15:0] result;
	logic        is_arith;
	logic        is_bool;
	logic        dest_en;     // destination clock allowed

	assign yd = instruction_latch[7:4];
	assign ys = instruction_latch[3:0];

	// selector to stack slot; stack read uses its own select
	function automatic logic [4:0] slot_of(input logic [4:0] sel);
		unique case (reg_sel_type'(sel))
			SEL_GEN_YD, SEL_INC, SEL_DEC: slot_of = {1'b0, yd};
			SEL_GEN_YS:  slot_of = {1'b0, ys};
			SEL_STATUS:  slot_of = `SLOT_STATUS;
			SEL_COUNTER: slot_of = `SLOT_COUNTER;
			SEL_SCR_A:   slot_of = `SLOT_SCRATCH_A;
			default:     slot_of = `SLOT_SCRATCH_B;
		endcase
	endfunction

	function automatic logic is_stack(input logic [4:0] sel);
		is_stack = (sel <= SEL_SCR_B) || (sel == SEL_INC) || (sel == SEL_DEC);
	endfunction

	// source mux onto the operand bus
	always_comb begin
		operand_bus = 16'h0000;
		if (mir.src == SEL_STATUS) begin
			// code on bits 0-3, three parts for the rest
			operand_bus = {stack[`SLOT_STATUS][15:4], condition_code};
		end else if (is_stack(mir.src)) begin
			// stack reads onto the operand bus
			operand_bus = stack[slot_of(mir.src)];
		end else if (mir.src == SEL_ADDR) begin
			operand_bus = memory_address_latch;
		end else if (mir.src == SEL_DATA) begin
			operand_bus = memory_data_latch;
		end else if (mir.src == SEL_OPERAND) begin
			operand_bus = second_operand_latch;
		end else if (mir.src == SEL_IO) begin
			operand_bus = IO_DATA_IN;
		end
	end

	// shifter ahead of alu a inputs
	always_comb begin
		unique case (shift_type'(mir.shift))
			SH_LEFT:  a_in = {operand_bus[14:0], 1'b0};
			SH_RIGHT: a_in = {1'b0, operand_bus[15:1]};
			SH_CROSS: a_in = {operand_bus[7:0], operand_bus[15:8]};
			default:  a_in = operand_bus;
		endcase
	end

	// b inputs blocked on command or skip option
	assign b_in = ((op_class == OP_CMD) || mir.skip_operand_input) ?
		16'h0000 : second_operand_latch;

	// alu; subtract formed as a plus not b plus one
	always_comb begin
		sum = {1'b0, a_in} + {1'b0, b_in};
		unique case (op_class)
			OP_ADD, OP_CMD: result = sum[15:0];
			OP_SUB: begin
				sum = {1'b0, a_in} + {1'b0, ~b_in} + 17'h0_0001;
				result = sum[15:0];
			end
			OP_AND:  result = a_in & b_in;
			OP_OR:   result = a_in | b_in;
			OP_XOR:  result = a_in ^ b_in;
			default: result = a_in; // load ignores b
		endcase
	end

	assign is_arith = (op_class == OP_ADD) || (op_class == OP_SUB);
	assign is_bool  = (op_class == OP_AND) || (op_class == OP_OR) || (op_class == OP_XOR);
	// no destination clock on skip, branch, decode, read
	assign dest_en  = exec && (mir.op <= OP_CMD) && (op_class != OP_BRANCH);

	// ----------------------------------------
	// register stack
	// ----------------------------------------
	// write select independent of read select
	always_ff @(posedge REF_CLK) begin
		if (dest_en && is_stack(mir.dst)) begin
			// stack entry loads from result bus
			stack[slot_of(mir.dst)] <= result;
		end
	end

	// ----------------------------------------
	// memory address and data
	// ----------------------------------------
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			memory_address_latch <= 16'h0000;
		end else if (dest_en && ((mir.dst == SEL_ADDR) || (mir.dst == SEL_COUNTER))) begin
			// load on address or counter destination
			memory_address_latch <= result;
		end
	end

	// slave copies the latch at memory cycle start
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			memory_address_slave <= 16'h0000;
		end else if (SLAVE_LOAD_STROBE) begin
			memory_address_slave <= memory_address_latch;
		end
	end

	// memory read outranks a result bus load in the same cycle
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			memory_data_latch <= 16'h0000;
		end else if (MEM_READ.strobe || MEM_READ.clear_data_high || MEM_READ.clear_data_low) begin
			// clear halves, then set active lines
			logic [15:0] kept;
			kept = memory_data_latch;
			if (MEM_READ.clear_data_high) begin
				kept[15:8] = 8'h00;
			end
			if (MEM_READ.clear_data_low) begin
				kept[7:0] = 8'h00;
			end
			memory_data_latch <= kept |
				(MEM_READ.strobe ? MEM_READ.strobed_memory_lines : 16'h0000);
		end else if (dest_en && (mir.dst == SEL_DATA)) begin
			if (mir.shift == SH_CROSS) begin
				// address bit 0 picks the half
				if (memory_address_latch[0]) begin
					memory_data_latch[15:8] <= result[15:8];
				end else begin
					memory_data_latch[7:0] <= result[7:0];
				end
			end else begin
				memory_data_latch <= result;
			end
		end
	end

	// ----------------------------------------
	// instruction latch and field counter
	// ----------------------------------------
	// fields: op 15:8, destination 7:4, source 3:0
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			instruction_latch <= 16'h0000;
		end else if (exec && (op_class == OP_IREAD)) begin
			instruction_latch <= memory_data_latch;
		end else if (dest_en && ((mir.src == SEL_INC) || (mir.dst == SEL_INC))) begin
			// increment field at end of word
			instruction_latch[7:4] <= yd + 4'h1;
		end else if (dest_en && ((mir.src == SEL_DEC) || (mir.dst == SEL_DEC))) begin
			instruction_latch[7:4] <= yd - 4'h1;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			second_operand_latch <= 16'h0000;
		end else if (dest_en && (mir.dst == SEL_OPERAND)) begin
			second_operand_latch <= result;
		end
	end

	// ----------------------------------------
	// flags and condition code
	// ----------------------------------------
	logic [3:0] next_flag_bank;
	logic       ovf;

	// signed overflow from operand and result signs
	assign ovf = (op_class == OP_ADD) ?
		((a_in[15] == b_in[15]) && (result[15] != a_in[15])) :
		((a_in[15] != b_in[15]) && (result[15] != a_in[15]));

	always_comb begin
		next_flag_bank = flag_bank;
		if (dest_en && ((mir.dst == SEL_FLAGS) || (mir.dst == SEL_STATUS))) begin
			next_flag_bank = result[3:0];
		end else if (dest_en) begin
			if (mir.carry_out && (is_arith || is_bool || (op_class == OP_LOAD))) begin
				if (mir.shift == SH_LEFT) begin
					next_flag_bank[`FLAG_C] = operand_bus[15];
				end else if (mir.shift == SH_RIGHT) begin
					next_flag_bank[`FLAG_C] = operand_bus[0];
				end else if (op_class == OP_ADD) begin
					next_flag_bank[`FLAG_C] = sum[16];
				end else if (op_class == OP_SUB) begin
					next_flag_bank[`FLAG_C] = !sum[16];
				end else begin
					next_flag_bank[`FLAG_C] = 1'b0;
				end
			end
			// signed overflow on add or subtract
			if (is_arith && !mir.suppress_flags) begin
				next_flag_bank[`FLAG_V] = ovf;
			end
			// greater and less from the result
			if ((is_arith || is_bool) && !mir.suppress_flags) begin
				next_flag_bank[`FLAG_G] = (!result[15] && (result != 16'h0000)) ||
					((result == 16'h0000) && (flag_bank[`FLAG_G] || flag_bank[`FLAG_L]));
				next_flag_bank[`FLAG_L] = result[15];
			end
		end
		if (FALSE_SYNC) begin
			next_flag_bank[`FLAG_V] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			flag_bank <= 4'h0;
		end else begin
			flag_bank <= next_flag_bank;
		end
	end

	// copy on instruction read or forced copy
	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			condition_code <= 4'h0;
		end else if (exec && (op_class == OP_IREAD)) begin
			condition_code <= flag_bank;
		end else if (dest_en && (op_class == OP_LOAD) && mir.force_condition_copy) begin
			condition_code <= flag_bank;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign MEM_ADDR         = memory_address_slave;
	assign MEM_WDATA        = memory_data_latch;
	assign MICROADDRESS     = microaddress_register;
	assign MICROINSTRUCTION = mir;
	assign INSTRUCTION      = instruction_latch;
	assign FLAGS            = flag_bank;
	assign CONDITION_CODE   = condition_code;
	assign RESULT_BUS       = result;
	assign SKIP_ACTIVE      = skip;
endmodule

// *** rtl/sequencer_regs.svh ***
`ifndef SEQUENCER_REGS_SVH
`define SEQUENCER_REGS_SVH
// ----------------------------------------
// power-up presets of the microinstruction
// ----------------------------------------
`define MIR_RESET_NORMAL   20'h3_0100
`define MIR_RESET_RESTART  20'h3_0102
// ----------------------------------------
// address constants
// ----------------------------------------
`define ILLEGAL_ENTRY      10'h008
`define ILLEGAL_BIT        3
`define HALFWORD_BIT       2
`define PAGE_WORDS         256
`define PAGE_COUNT         3
`define PART_COUNT         5
// ----------------------------------------
// register stack slots
// ----------------------------------------
`define SLOT_STATUS        5'h10
`define SLOT_COUNTER       5'h11
`define SLOT_SCRATCH_A     5'h12
`define SLOT_SCRATCH_B     5'h13
`define STACK_DEPTH        20
// ----------------------------------------
// flag bank bit positions (c v g l)
// ----------------------------------------
`define FLAG_C             3
`define FLAG_V             2
`define FLAG_G             1
`define FLAG_L             0
`endif

// *** rtl/sequencer_pkg.sv ***
package sequencer_pkg;
	// ----------------------------------------
	// micro operation classes
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_LOAD   = 4'b0000,
		OP_ADD    = 4'b0001,
		OP_SUB    = 4'b0010,
		OP_BRANCH = 4'b0011,
		OP_AND    = 4'b0100,
		OP_OR     = 4'b0101,
		OP_XOR    = 4'b0110,
		OP_CMD    = 4'b0111,
		OP_DECODE = 4'b1000,
		OP_IREAD  = 4'b1001
	} micro_class_type;

	// ----------------------------------------
	// source and destination selectors
	// ----------------------------------------
	typedef enum logic [4:0] {
		SEL_GEN_YD  = 5'b00000,
		SEL_GEN_YS  = 5'b00001,
		SEL_STATUS  = 5'b00010,
		SEL_COUNTER = 5'b00011,
		SEL_SCR_A   = 5'b00100,
		SEL_SCR_B   = 5'b00101,
		SEL_ADDR    = 5'b00110,
		SEL_DATA    = 5'b00111,
		SEL_OPERAND = 5'b01000,
		SEL_INC     = 5'b01001,
		SEL_DEC     = 5'b01010,
		SEL_IO      = 5'b01011,
		SEL_FLAGS   = 5'b01100,
		SEL_NONE    = 5'b01101
	} reg_sel_type;

	typedef enum logic [1:0] {
		SH_NONE  = 2'b00,
		SH_LEFT  = 2'b01,
		SH_RIGHT = 2'b10,
		SH_CROSS = 2'b11
	} shift_type;

	// ----------------------------------------
	// microinstruction word, 20 bits
	// ----------------------------------------
	typedef struct packed {
		logic [3:0] op;
		logic [4:0] dst;
		logic [4:0] src;
		logic       suppress_flags;
		logic       skip_operand_input;
		logic       force_condition_copy;
		logic       carry_out;
		logic [1:0] shift;
	} micro_word_type;

	// ----------------------------------------
	// memory read strobe group
	// ----------------------------------------
	typedef struct packed {
		logic        clear_data_high;
		logic        clear_data_low;
		logic        strobe;
		logic [15:0] strobed_memory_lines;
	} mem_read_type;

	// ----------------------------------------
	// load port for the store contents
	// ----------------------------------------
	typedef struct packed {
		logic        cs_we;
		logic [9:0]  cs_addr;
		logic [19:0] cs_data;
		logic        decode_rom_we;
		logic [7:0]  decode_rom_addr;
		logic [11:0] decode_rom_data;
		logic        legal_we;
		logic [7:0]  legal_addr;
		logic        legal_bit;
	} store_load_type;
endpackage

// *** testbench/sequencer_monitor.sv ***
`timescale 1ns/100ps
module sequencer_monitor import sequencer_pkg::*; #(
	parameter bit AUTO_RESTART = 1'b0,
	parameter int PAGES        = 3
) (
	input wire logic           REF_CLK,
	input wire logic           NRST,
	input wire mem_read_type   MEM_READ,
	input wire logic           SLAVE_LOAD_STROBE,
	input wire logic           FALSE_SYNC,
	input wire logic [15:0]    MEM_ADDR,
	input wire logic [15:0]    MEM_WDATA,
	input wire logic [9:0]     MICROADDRESS,
	input wire micro_word_type MICROINSTRUCTION,
	input wire logic [3:0]     FLAGS,
	input wire logic           SKIP_ACTIVE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// a decode or instruction read that really executes
	sequence two_cycle_s;
		!SKIP_ACTIVE && MICROINSTRUCTION.op inside {OP_DECODE, OP_IREAD};
	endsequence
	// one stalled cycle, then work resumes
	sequence skip_once_s;
		SKIP_ACTIVE ##1 !SKIP_ACTIVE;
	endsequence
	preset_word_a: assert property (
		$rose(NRST) |-> MICROINSTRUCTION == (AUTO_RESTART ? 20'h3_0102 : 20'h3_0100))
		else $error("preset word wrong");
	decode_skip_a: assert property (
		two_cycle_s |=> skip_once_s)
		else $error("decode or read did not stall once");
	skip_single_a: assert property (
		SKIP_ACTIVE |=> !SKIP_ACTIVE)
		else $error("stall longer than one cycle");
	page_count_a: assert property (
		!SKIP_ACTIVE && !(MICROINSTRUCTION.op inside {OP_BRANCH, OP_DECODE, OP_IREAD})
		|=> MICROADDRESS == {$past(MICROADDRESS[9:8]), $past(MICROADDRESS[7:0]) + 8'h01})
		else $error("microaddress did not step in page");
	slave_hold_a: assert property (
		!SLAVE_LOAD_STROBE |=> $stable(MEM_ADDR))
		else $error("slave address moved without strobe");
	read_fill_a: assert property (
		MEM_READ.strobe |=> (MEM_WDATA & $past(MEM_READ.strobed_memory_lines))
		== $past(MEM_READ.strobed_memory_lines))
		else $error("strobed bits not set");
	clear_high_a: assert property (
		MEM_READ.clear_data_high && !MEM_READ.strobe |=> MEM_WDATA[15:8] == 8'h00)
		else $error("high half not cleared");
	false_sync_a: assert property (
		FALSE_SYNC |=> FLAGS[2])
		else $error("overflow not set by false sync");
endmodule

// *** testbench/core_memory_model.sv ***
`timescale 1ns/100ps
module core_memory_model import sequencer_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rd,
	input  wire logic [15:0] addr,
	output mem_read_type     mem
);
	initial mem = '0;
	// idle lines keep toggling so stale data is never mistaken for a word
	// clear then set
	always @(posedge clk) begin
		mem.strobe <= 1'b0;
		mem.strobed_memory_lines <= ~mem.strobed_memory_lines;
		mem.clear_data_high <= rd;
		mem.clear_data_low <= rd;
		if (mem.clear_data_high) begin
			mem.strobe <= 1'b1;
			mem.strobed_memory_lines <= addr ^ 16'ha5c3;
		end
	end
endmodule

// *** testbench/microcode_sequencer_registers_tb.sv ***
`timescale 1ns/100ps
module microcode_sequencer_registers_tb import sequencer_pkg::*;;
	typedef struct packed {
		micro_class_type op;
		logic [1:0]      fn;
		shift_type       sh;
		logic [15:0]     a;
		logic [15:0]     b;
		logic [15:0]     res;
		logic [3:0]      fl;
	} row_type;
	// fn is {suppress flags, skip operand}; fl is {c, v, g, l}
	row_type rows [11] = '{
		'{OP_ADD,  2'h0, SH_NONE,  16'h7fff, 16'h0001, 16'h8000, 4'h5},
		'{OP_SUB,  2'h0, SH_NONE,  16'h0003, 16'h0005, 16'hfffe, 4'h9},
		'{OP_ADD,  2'h0, SH_NONE,  16'hffff, 16'h0001, 16'h0000, 4'ha},
		'{OP_AND,  2'h0, SH_NONE,  16'h00f0, 16'h0f00, 16'h0000, 4'h2},
		'{OP_OR,   2'h0, SH_NONE,  16'h8000, 16'h0001, 16'h8001, 4'h1},
		'{OP_XOR,  2'h0, SH_NONE,  16'h1234, 16'h1234, 16'h0000, 4'h2},
		'{OP_SUB,  2'h0, SH_NONE,  16'h8000, 16'h0001, 16'h7fff, 4'h6},
		'{OP_ADD,  2'h2, SH_NONE,  16'h0001, 16'h0001, 16'h0002, 4'h6},
		'{OP_LOAD, 2'h0, SH_LEFT,  16'h0000, 16'h8001, 16'h0000, 4'he},
		'{OP_LOAD, 2'h0, SH_RIGHT, 16'h0000, 16'h0002, 16'h0000, 4'h6},
		'{OP_ADD,  2'h1, SH_NONE,  16'h1234, 16'h1111, 16'h1234, 4'h2}};
	logic           REF_CLK = 1'b0;
	logic           NRST = 1'b0;
	logic           SLAVE_LOAD_STROBE = 1'b0;
	logic           HALFWORD_XFER = 1'b0;
	logic           FALSE_SYNC = 1'b0;
	logic           rd = 1'b0;
	logic [15:0]    IO_DATA_IN;
	store_load_type STORE_LOAD = '0;
	mem_read_type   MEM_READ;
	logic [15:0]    MEM_ADDR, MEM_WDATA, INSTRUCTION, RESULT_BUS;
	logic [9:0]     MICROADDRESS;
	micro_word_type MICROINSTRUCTION, w_opnd, w_addr, w_dec;
	logic [3:0]     FLAGS, CONDITION_CODE;
	logic           SKIP_ACTIVE;
	int             errors = 0;
	int             checks_done = 0;
	microcode_sequencer_registers u_microcode_sequencer_registers (.*);
	core_memory_model u_core_memory_model (.clk(REF_CLK), .rd(rd), .addr(MEM_ADDR), .mem(MEM_READ));
	always #25 REF_CLK = ~REF_CLK;
	function automatic micro_word_type mw(logic [3:0] o, logic [4:0] d, s, logic [1:0] fn, logic co, logic [1:0] sh);
		return {o, d, s, fn, 1'b0, co, sh};
	endfunction
	// row word: shift rows read the operand latch, others read the io bus
	function automatic micro_word_type word(row_type r);
		return mw(r.op, SEL_SCR_A, (r.sh != SH_NONE) ? SEL_OPERAND : SEL_IO, r.fn, 1'b1, r.sh);
	endfunction
	task chk(logic [19:0] got, logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// control store write, caller lowers the strobe one edge later
	task put(logic [9:0] a, micro_word_type d);
		STORE_LOAD.cs_we <= 1'b1;
		STORE_LOAD.cs_addr <= a;
		STORE_LOAD.cs_data <= d;
	endtask
	task wait_word(micro_word_type w);
		repeat (20) begin
			@(posedge REF_CLK);
			#1;
			if (MICROINSTRUCTION === w) break;
		end
		chk(MICROINSTRUCTION, w);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog at 400 cycles, well beyond the expected run of under two hundred cycles
	initial begin
		#20000;
		errors++;
		print_verdict;
	end
	initial begin
		w_opnd = mw(OP_LOAD, SEL_OPERAND, SEL_IO, 2'h0, 1'b0, SH_NONE);
		w_addr = mw(OP_LOAD, SEL_ADDR, SEL_SCR_A, 2'h0, 1'b0, SH_NONE);
		w_dec = mw(OP_DECODE, SEL_NONE, SEL_NONE, 2'h0, 1'b0, SH_NONE);
		IO_DATA_IN = rows[0].b;
		// load a four word loop while still in reset
		@(posedge REF_CLK); put(10'h100, w_opnd);
		#1;
		chk(MICROINSTRUCTION, 20'h3_0100);
		@(posedge REF_CLK); put(10'h101, word(rows[0]));
		@(posedge REF_CLK); put(10'h102, w_addr);
		@(posedge REF_CLK); put(10'h103, 20'h3_0100);
		NRST <= 1'b1;
		@(posedge REF_CLK); STORE_LOAD.cs_we <= 1'b0;
		for (int i = 0; i < 11; i++) begin
			wait_word(w_opnd);
			@(posedge REF_CLK); IO_DATA_IN <= rows[i].a;
			#1;
			if (rows[i].sh == SH_NONE) chk(RESULT_BUS, rows[i].res);
			@(posedge REF_CLK); #1;
			chk(FLAGS, rows[i].fl);
			@(posedge REF_CLK);
			@(posedge REF_CLK); SLAVE_LOAD_STROBE <= 1'b1;
			put(10'h101, word(rows[(i + 1) % 11]));
			@(posedge REF_CLK); SLAVE_LOAD_STROBE <= 1'b0;
			STORE_LOAD.cs_we <= 1'b0;
			IO_DATA_IN <= rows[(i + 1) % 11].b;
			#1;
			if (rows[i].sh == SH_NONE) chk(MEM_ADDR, rows[i].res);
		end
		// memory read of the last slave address
		@(posedge REF_CLK); rd <= 1'b1;
		@(posedge REF_CLK); rd <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		#1;
		chk(MEM_WDATA, 16'h1234 ^ 16'ha5c3);
		@(posedge REF_CLK); FALSE_SYNC <= 1'b1;
		@(posedge REF_CLK); FALSE_SYNC <= 1'b0;
		#1;
		chk(FLAGS[2], 1'b1);
		// op code zero is illegal out of reset
		@(posedge REF_CLK); put(10'h101, w_dec);
		@(posedge REF_CLK); STORE_LOAD.cs_we <= 1'b0;
		wait_word(w_dec);
		@(posedge REF_CLK); #1;
		chk({SKIP_ACTIVE, MICROADDRESS}, {1'b1, 10'h008});
		print_verdict;
	end
endmodule
bind microcode_sequencer_registers sequencer_monitor #(.AUTO_RESTART(AUTO_RESTART), .PAGES(PAGES)) u_sequencer_monitor (.*);
